// ### rtl/counter8_pkg.sv
// Constants shared by the 8-bit timer/counter and its tick generator.
package counter8_pkg;

  // Count range limits.
  localparam logic [7:0] BOTTOM = 8'h00;
  localparam logic [7:0] MAX = 8'hff;

  // Waveform mode field codes.
  localparam logic [1:0] WGM_NORMAL = 2'h0;
  localparam logic [1:0] WGM_PHASE = 2'h1;
  localparam logic [1:0] WGM_CTC = 2'h2;
  localparam logic [1:0] WGM_FAST = 2'h3;

  // Output mode codes.
  localparam logic [1:0] OM_NONE = 2'h0;
  localparam logic [1:0] OM_TOGGLE = 2'h1;
  localparam logic [1:0] OM_CLEAR = 2'h2;
  localparam logic [1:0] OM_SET = 2'h3;

  // Clock select codes.
  localparam logic [2:0] CS_STOP = 3'h0;
  localparam logic [2:0] CS_DIV1 = 3'h1;
  localparam logic [2:0] CS_DIV8 = 3'h2;
  localparam logic [2:0] CS_DIV64 = 3'h3;
  localparam logic [2:0] CS_DIV256 = 3'h4;
  localparam logic [2:0] CS_DIV1024 = 3'h5;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [2:0] CS_EXT_RISE = 3'h7;

  // Prescaler masks: a tick fires when the masked bits are all ones.
  localparam logic [9:0] PRE_MASK_1 = 10'h000;
  localparam logic [9:0] PRE_MASK_8 = 10'h007;
  localparam logic [9:0] PRE_MASK_64 = 10'h03f;
  localparam logic [9:0] PRE_MASK_256 = 10'h0ff;
  localparam logic [9:0] PRE_MASK_1024 = 10'h3ff;

endpackage : counter8_pkg

// ### rtl/counter8_tick_gen.sv
// Timer tick generator: prescaler and synchronised external count pin.
`timescale 1ns/10ps
`default_nettype none

module counter8_tick_gen (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Source selection.
  input wire logic [2:0] clock_select_field,
  // External count pin, asynchronous.
  input wire logic ext_count_pin,
  // One-cycle enable for the counter.
  output logic timer_tick
);

  typedef struct packed {
    logic [9:0] pre;
    logic s1;
    logic s2;
    logic s3;
    logic level;
    logic [1:0] fill;
    logic tick;
  } tick_state_s;

  tick_state_s s_q;
  tick_state_s s_d;
  logic [9:0] mask;
  logic rise;
  logic fall;

  // Prescaler mask selection and external edge detection on agreed levels.
  always_comb begin
    s_d = s_q;
    mask = counter8_pkg::PRE_MASK_1;
    rise = 1'b0;
    fall = 1'b0;
    s_d.pre = s_q.pre + 10'h001;
    s_d.s1 = ext_count_pin;
    s_d.s2 = s_q.s1;
    s_d.s3 = s_q.s2;
    // Until the chain has filled after reset the level is adopted without
    // an edge, so a pin that idles high gives no false count.
    if (s_q.fill != 2'h3) begin
      s_d.fill = s_q.fill + 2'h1;
      s_d.level = s_q.s2;
    end else if (s_q.s2 == s_q.s3 && s_q.s3 != s_q.level) begin
      // Only a level seen by both later stages counts.
      s_d.level = s_q.s3;
      rise = s_q.s3;
      fall = !s_q.s3;
    end
    unique case (clock_select_field)
      counter8_pkg::CS_DIV8: mask = counter8_pkg::PRE_MASK_8;
      counter8_pkg::CS_DIV64: mask = counter8_pkg::PRE_MASK_64;
      counter8_pkg::CS_DIV256: mask = counter8_pkg::PRE_MASK_256;
      counter8_pkg::CS_DIV1024: mask = counter8_pkg::PRE_MASK_1024;
      default: mask = counter8_pkg::PRE_MASK_1;
    endcase
    unique case (clock_select_field)
      counter8_pkg::CS_STOP: s_d.tick = 1'b0;
      counter8_pkg::CS_EXT_FALL: s_d.tick = fall;
      counter8_pkg::CS_EXT_RISE: s_d.tick = rise;
      default: s_d.tick = ((s_q.pre & mask) == mask);
    endcase
  end

  // State register.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign timer_tick = s_q.tick;

  a_stop_no_tick: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    clock_select_field == counter8_pkg::CS_STOP |=> !timer_tick)
    else $error("Tick seen while clock select is stopped.");

endmodule : counter8_tick_gen

`default_nettype wire

// ### rtl/counter8_compare_unit.sv
// 8-bit timer/counter with one output compare channel and pin override.
`timescale 1ns/10ps
`default_nettype none

module counter8_compare_unit (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Configuration.
  input wire logic [2:0] clock_select_field,
  input wire logic [1:0] waveform_mode_field,
  input wire logic [1:0] output_mode_bits,
  input wire logic compare_irq_enable,
  input wire logic overflow_irq_enable,
  input wire logic global_irq_enable,
  // Software writes.
  input wire logic count_write,
  input wire logic [7:0] count_write_data,
  input wire logic compare_write,
  input wire logic [7:0] compare_write_data,
  input wire logic force_compare_strobe,
  input wire logic compare_flag_clear,
  input wire logic overflow_flag_clear,
  // Interrupt service acknowledges.
  input wire logic compare_irq_ack,
  input wire logic overflow_irq_ack,
  // External count pin and general port.
  input wire logic ext_count_pin,
  input wire logic port_data,
  input wire logic compare_pin_direction,
  // Status.
  output logic [7:0] count_value,
  output logic [7:0] compare_value,
  output logic compare_flag,
  output logic overflow_flag,
  output logic compare_irq,
  output logic overflow_irq,
  output logic at_bottom,
  output logic at_max,
  output logic compare_output,
  // Pin drive.
  output logic pin_out,
  output logic pin_oe
);

  typedef struct packed {
    logic [7:0] cnt;
    logic [7:0] ocr;
    logic [7:0] ocr_buf;
    logic [7:0] cmp_view;
    logic down;
    logic block;
    logic cflag;
    logic oflag;
    logic cirq;
    logic oirq;
    logic oc;
    logic bottom;
    logic max;
    logic pin_out;
    logic pin_oe;
  } unit_state_s;

  unit_state_s s_q;
  unit_state_s s_d;
  logic timer_tick;
  logic pwm;
  logic match;
  logic cset;
  logic oset;
  logic [7:0] top;

  // Tick source for the counter.
  counter8_tick_gen u_tick (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .clock_select_field(clock_select_field),
    .ext_count_pin(ext_count_pin),
    .timer_tick(timer_tick)
  );

  // Counter, compare, flags and waveform update.
  always_comb begin
    s_d = s_q;
    pwm = waveform_mode_field[0]; // Modes one and three are the PWM modes.
    top = (waveform_mode_field == counter8_pkg::WGM_CTC) ?
          s_q.ocr : counter8_pkg::MAX;
    // A blocked tick ignores equality so a preset compare cannot fire.
    match = (s_q.cnt == s_q.ocr) && !s_q.block;
    cset = timer_tick && match;
    oset = 1'b0;

    if (timer_tick) begin
      s_d.block = 1'b0;
      unique case (waveform_mode_field)
        counter8_pkg::WGM_NORMAL: begin
          s_d.cnt = s_q.cnt + 8'h01;
          oset = (s_q.cnt == counter8_pkg::MAX);
        end
        counter8_pkg::WGM_CTC: begin
          if (s_q.cnt == top && match) begin
            s_d.cnt = counter8_pkg::BOTTOM;
          end else begin
            s_d.cnt = s_q.cnt + 8'h01;
          end
          oset = (s_q.cnt == counter8_pkg::MAX);
        end
        counter8_pkg::WGM_FAST: begin
          if (s_q.cnt == top) begin
            s_d.cnt = counter8_pkg::BOTTOM;
          end else begin
            s_d.cnt = s_q.cnt + 8'h01;
          end
          oset = (s_q.cnt == counter8_pkg::MAX);
        end
        counter8_pkg::WGM_PHASE: begin
          // Turn around at both ends so each end value is held one tick.
          if (!s_q.down) begin
            if (s_q.cnt == top) begin
              s_d.down = 1'b1;
              s_d.cnt = s_q.cnt - 8'h01;
            end else begin
              s_d.cnt = s_q.cnt + 8'h01;
            end
          end else begin
            if (s_q.cnt == counter8_pkg::BOTTOM) begin
              s_d.down = 1'b0;
              s_d.cnt = s_q.cnt + 8'h01;
            end else begin
              s_d.cnt = s_q.cnt - 8'h01;
            end
          end
          oset = (s_q.cnt == counter8_pkg::BOTTOM);
        end
      endcase
      // Buffered compare value moves in at top of the PWM sequence.
      if (pwm && s_q.cnt == top) begin
        s_d.ocr = s_q.ocr_buf;
      end
    end

    // Only phase-correct mode may count down.
    if (waveform_mode_field != counter8_pkg::WGM_PHASE) begin
      s_d.down = 1'b0;
    end

    // Software counter write wins over the tick result.
    if (count_write) begin
      s_d.cnt = count_write_data;
      s_d.block = 1'b1;
    end

    // Compare value access goes to buffer or live register by mode.
    if (compare_write) begin
      s_d.ocr_buf = compare_write_data;
      if (!pwm) begin
        s_d.ocr = compare_write_data;
      end
    end
    s_d.cmp_view = pwm ? s_d.ocr_buf : s_d.ocr;

    // Waveform output; output mode bits act at once, unbuffered.
    if (!pwm) begin
      if (cset || force_compare_strobe) begin
        unique case (output_mode_bits)
          counter8_pkg::OM_TOGGLE: s_d.oc = !s_q.oc;
          counter8_pkg::OM_CLEAR: s_d.oc = 1'b0;
          counter8_pkg::OM_SET: s_d.oc = 1'b1;
          counter8_pkg::OM_NONE: s_d.oc = s_q.oc;
        endcase
      end
    end else if (output_mode_bits[1]) begin
      // Code two is non-inverting; code three inverts. Code one does nothing.
      if (waveform_mode_field == counter8_pkg::WGM_FAST) begin
        if (cset) begin
          s_d.oc = output_mode_bits[0];
        end else if (timer_tick && s_q.cnt == counter8_pkg::MAX) begin
          s_d.oc = !output_mode_bits[0];
        end
      end else if (cset) begin
        s_d.oc = output_mode_bits[0] ^ s_q.down;
      end
    end

    // Flags: hardware set wins over a clear in the same cycle.
    if (compare_flag_clear || compare_irq_ack) begin
      s_d.cflag = 1'b0;
    end
    if (cset) begin
      s_d.cflag = 1'b1;
    end
    if (overflow_flag_clear || overflow_irq_ack) begin
      s_d.oflag = 1'b0;
    end
    if (timer_tick && oset) begin
      s_d.oflag = 1'b1;
    end
    s_d.cirq = s_d.cflag && compare_irq_enable && global_irq_enable;
    s_d.oirq = s_d.oflag && overflow_irq_enable && global_irq_enable;

    // Range indications track the counter as it is registered.
    s_d.bottom = (s_d.cnt == counter8_pkg::BOTTOM);
    s_d.max = (s_d.cnt == counter8_pkg::MAX);

    // Pin drive; override does not depend on the waveform mode.
    s_d.pin_out = (output_mode_bits != counter8_pkg::OM_NONE) ?
                  s_q.oc : port_data;
    s_d.pin_oe = compare_pin_direction;
  end

  // State register; the compare output resets to zero only here.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      s_q <= '0;
      s_q.bottom <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign count_value = s_q.cnt;
  assign compare_value = s_q.cmp_view;
  assign compare_flag = s_q.cflag;
  assign overflow_flag = s_q.oflag;
  assign compare_irq = s_q.cirq;
  assign overflow_irq = s_q.oirq;
  assign at_bottom = s_q.bottom;
  assign at_max = s_q.max;
  assign compare_output = s_q.oc;
  assign pin_out = s_q.pin_out;
  assign pin_oe = s_q.pin_oe;

  a_bottom_tracks: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    at_bottom == (count_value == 8'h00))
    else $error("Bottom indication disagrees with counter.");

  a_max_tracks: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    at_max == (count_value == 8'hff))
    else $error("Maximum indication disagrees with counter.");

  a_write_wins: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    count_write |=> count_value == $past(count_write_data))
    else $error("Counter write lost to count logic.");

  a_flag_set: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    cset |=> compare_flag)
    else $error("Compare match did not set the flag.");

  a_flag_clear: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    compare_flag_clear && !cset |=> !compare_flag)
    else $error("Write of one did not clear the compare flag.");

  a_block_match: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    count_write ##1 (!count_write && timer_tick)[*1] |-> !cset)
    else $error("Compare match not blocked after counter write.");

  a_irq_gate: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    compare_irq |-> compare_flag && $past(compare_irq_enable))
    else $error("Compare interrupt without flag or enable.");

  a_force_noflag: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    force_compare_strobe && !cset && !compare_flag |=> !compare_flag)
    else $error("Force strobe set the compare flag.");

  a_pin_override: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    output_mode_bits != 2'h0 |=> pin_out == $past(compare_output))
    else $error("Pin not driven from compare output under override.");

  a_pin_dir: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    compare_pin_direction ##1 compare_pin_direction |-> pin_oe)
    else $error("Pin enable does not follow direction bit.");

  // Without a tick or a write the counter must stand still.
  a_count_hold: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    !timer_tick && !count_write |=> count_value == $past(count_value))
    else $error("Counter moved without a tick or a write.");

  // Normal and fast modes only ever step up; the wrap is plain 8-bit carry.
  a_up_count: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    (waveform_mode_field == counter8_pkg::WGM_NORMAL ||
     waveform_mode_field == counter8_pkg::WGM_FAST) &&
    timer_tick && !count_write |=>
    count_value == $past(count_value) + 8'h01)
    else $error("Counter did not step up by one in an up-only mode.");

  a_ctc_clear: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    waveform_mode_field == counter8_pkg::WGM_CTC && timer_tick && match &&
    !count_write |=> count_value == 8'h00)
    else $error("Clear-on-match mode did not clear the counter.");

  // The live compare value may only move in at top while buffering.
  a_buffer_hold: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    pwm && !(timer_tick && s_q.cnt == top) |=> s_q.ocr == $past(s_q.ocr))
    else $error("Buffered compare value moved in away from top.");

  a_pwm_noforce: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    pwm && force_compare_strobe && !timer_tick |=>
    compare_output == $past(compare_output))
    else $error("Force strobe changed the output in a PWM mode.");

  a_none_hold: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    output_mode_bits == counter8_pkg::OM_NONE |=>
    compare_output == $past(compare_output))
    else $error("Output mode zero changed the compare output.");

  a_ovf_set: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    timer_tick && oset |=> overflow_flag)
    else $error("Overflow point did not set the overflow flag.");

  a_ovf_gate: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    overflow_irq |-> overflow_flag && $past(overflow_irq_enable) &&
    $past(global_irq_enable))
    else $error("Overflow interrupt without flag or enable.");

endmodule : counter8_compare_unit

`default_nettype wire

// ### bench/tb_counter8_compare_unit.sv
// Self-checking testbench for the 8-bit timer/counter compare unit.
`timescale 1ns/10ps
`default_nettype none

module tb_counter8_compare_unit;
  // Clock, reset and configuration.
  logic ref_clk, sys_rst;
  logic [2:0] clock_select_field;
  logic [1:0] waveform_mode_field, output_mode_bits;
  logic compare_irq_enable, overflow_irq_enable, global_irq_enable;
  // Software strobes and data.
  logic count_write, compare_write, force_compare_strobe;
  logic [7:0] count_write_data, compare_write_data;
  logic compare_flag_clear, overflow_flag_clear;
  logic compare_irq_ack, overflow_irq_ack;
  logic ext_count_pin, port_data, compare_pin_direction;
  // Observed outputs.
  logic [7:0] count_value, compare_value;
  logic compare_flag, overflow_flag, compare_irq, overflow_irq;
  logic at_bottom, at_max, compare_output, pin_out, pin_oe;
  int miscompares, samples_checked, cycles;
  int k;

  counter8_compare_unit DUT (
    .ref_clk, .sys_rst, .clock_select_field, .waveform_mode_field,
    .output_mode_bits, .compare_irq_enable, .overflow_irq_enable,
    .global_irq_enable, .count_write, .count_write_data, .compare_write,
    .compare_write_data, .force_compare_strobe, .compare_flag_clear,
    .overflow_flag_clear, .compare_irq_ack, .overflow_irq_ack,
    .ext_count_pin, .port_data, .compare_pin_direction, .count_value,
    .compare_value, .compare_flag, .overflow_flag, .compare_irq,
    .overflow_irq, .at_bottom, .at_max, .compare_output, .pin_out, .pin_oe
  );

  // Free-running 125 MHz clock.
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  // Prints the counts and the verdict, then stops the run.
  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : test_done

  // A hung wait must not stall the run forever.
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      test_done();
    end
  end

  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // All driving tasks start and end at a falling edge.
  task automatic run(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : run

  task automatic wr_count(input logic [7:0] v);
    count_write = 1'b1;
    count_write_data = v;
    run(1);
    count_write = 1'b0;
  endtask : wr_count

  task automatic wr_compare(input logic [7:0] v);
    compare_write = 1'b1;
    compare_write_data = v;
    run(1);
    compare_write = 1'b0;
  endtask : wr_compare

  // One-cycle strobe: 0 force, 1 flag clear, 2 compare ack, 3 overflow ack,
  // 4 overflow flag clear.
  task automatic strobe(input int which);
    case (which)
      0: force_compare_strobe = 1'b1;
      1: compare_flag_clear = 1'b1;
      2: compare_irq_ack = 1'b1;
      3: overflow_irq_ack = 1'b1;
      default: overflow_flag_clear = 1'b1;
    endcase
    run(1);
    force_compare_strobe = 1'b0;
    compare_flag_clear = 1'b0;
    compare_irq_ack = 1'b0;
    overflow_irq_ack = 1'b0;
    overflow_flag_clear = 1'b0;
  endtask : strobe

  // Bounded waits on the counter value and on the compare flag.
  task automatic wait_cnt(input logic [7:0] v, input int limit);
    int i;
    i = 0;
    while (count_value !== v && i < limit) begin
      run(1);
      i++;
    end
    check("count_value", count_value, v);
  endtask : wait_cnt

  task automatic wait_flag(input int limit);
    int i;
    i = 0;
    while (compare_flag !== 1'b1 && i < limit) begin
      run(1);
      i++;
    end
    check("compare_flag", compare_flag, 8'h01);
  endtask : wait_flag

  // Force table: output mode and expected compare output after the strobe.
  logic [1:0] f_mode [5] = '{2'h3, 2'h2, 2'h1, 2'h1, 2'h0};
  logic f_exp [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0};

  initial begin
    {clock_select_field, waveform_mode_field, output_mode_bits} = '0;
    {compare_irq_enable, overflow_irq_enable, global_irq_enable} = 3'h7;
    {count_write, compare_write, force_compare_strobe} = '0;
    {count_write_data, compare_write_data} = '0;
    {compare_flag_clear, overflow_flag_clear} = '0;
    {compare_irq_ack, overflow_irq_ack} = '0;
    {ext_count_pin, port_data, compare_pin_direction} = 3'h6;
    sys_rst = 1'b1;
    run(20);
    sys_rst = 1'b0;
    run(1);
    check("compare_output", compare_output, 8'h00);
    check("at_bottom", at_bottom, 8'h01);
    $display("test reset done");

    // Stopped counter: writes land, no counting.
    wr_count(8'hff);
    run(5);
    check("count_value", count_value, 8'hff);
    check("at_max", at_max, 8'h01);
    check("at_bottom", at_bottom, 8'h00);
    wr_count(8'h42);
    $display("test stopped done");

    // Forced matches in normal mode, pin source follows the output mode.
    for (k = 0; k < 5; k++) begin
      output_mode_bits = f_mode[k];
      strobe(0);
      run(2);
      check("compare_output", compare_output, 8'(f_exp[k]));
      check("pin_out", pin_out, 8'(k == 4 ? 1'b1 : f_exp[k]));
      check("compare_flag", compare_flag, 8'h00);
    end
    check("count_value", count_value, 8'h42);
    output_mode_bits = 2'h3;
    strobe(0);
    waveform_mode_field = 2'h3;
    output_mode_bits = 2'h2;
    strobe(0);
    compare_pin_direction = 1'b1;
    run(2);
    check("compare_output", compare_output, 8'h01);
    check("pin_out", pin_out, 8'h01);
    check("pin_oe", pin_oe, 8'h01);
    compare_pin_direction = 1'b0;
    run(2);
    check("pin_oe", pin_oe, 8'h00);
    $display("test force done");

    // Normal mode: a counter write equal to the compare value is blocked.
    waveform_mode_field = 2'h0;
    wr_compare(8'h10);
    check("compare_value", compare_value, 8'h10);
    wr_count(8'h10);
    clock_select_field = 3'h1;
    run(20);
    check("compare_flag", compare_flag, 8'h00);
    check("count_value", count_value, 8'h10 + 8'd19);
    clock_select_field = 3'h0;
    wr_count(8'h0c);
    clock_select_field = 3'h1;
    wait_flag(20);
    check("compare_irq", compare_irq, 8'h01);
    global_irq_enable = 1'b0;
    run(2);
    check("compare_irq", compare_irq, 8'h00);
    global_irq_enable = 1'b1;
    compare_irq_enable = 1'b0;
    run(2);
    check("compare_irq", compare_irq, 8'h00);
    compare_irq_enable = 1'b1;
    strobe(1);
    run(1);
    check("compare_flag", compare_flag, 8'h00);
    wait_flag(300);
    strobe(2);
    run(1);
    check("compare_flag", compare_flag, 8'h00);
    $display("test match done");

    // Overflow when the counter wraps from maximum to zero.
    wr_count(8'hfd);
    wait_cnt(8'h00, 10);
    check("overflow_flag", overflow_flag, 8'h01);
    check("overflow_irq", overflow_irq, 8'h01);
    overflow_irq_enable = 1'b0;
    run(2);
    check("overflow_irq", overflow_irq, 8'h00);
    overflow_irq_enable = 1'b1;
    strobe(3);
    run(1);
    check("overflow_flag", overflow_flag, 8'h00);
    $display("test overflow done");

    // Clear-on-match: the compare value becomes the top.
    clock_select_field = 3'h0;
    waveform_mode_field = 2'h2;
    wr_compare(8'h05);
    wr_count(8'h00);
    clock_select_field = 3'h1;
    wait_cnt(8'h05, 12);
    wait_cnt(8'h00, 3);
    for (k = 0; k < 20; k++) begin
      run(1);
      check("ctc range", 8'(count_value <= 8'h05), 8'h01);
    end
    $display("test ctc done");

    // Fast PWM: compare writes wait in the buffer, old value still matches.
    clock_select_field = 3'h0;
    waveform_mode_field = 2'h3;
    wr_compare(8'h80);
    check("compare_value", compare_value, 8'h80);
    wr_count(8'h00);
    strobe(1);
    clock_select_field = 3'h1;
    wait_flag(12);
    clock_select_field = 3'h0;
    wr_count(8'hfd);
    clock_select_field = 3'h1;
    wait_cnt(8'h00, 10);
    // The buffered value is live now: no match at the old value any more.
    strobe(1);
    wait_cnt(8'h7f, 140);
    check("compare_flag", compare_flag, 8'h00);
    wait_flag(4);
    $display("test fast pwm done");

    // Phase-correct PWM turns at maximum and counts down.
    clock_select_field = 3'h0;
    waveform_mode_field = 2'h1;
    wr_count(8'hfe);
    clock_select_field = 3'h1;
    wait_cnt(8'hfc, 12);
    strobe(4);
    check("overflow_flag", overflow_flag, 8'h00);
    wait_cnt(8'h00, 260);
    run(1);
    check("count_value", count_value, 8'h01);
    check("overflow_flag", overflow_flag, 8'h01);
    $display("test phase pwm done");

    // External falling edges count once; then divide by eight for 65 cycles.
    clock_select_field = 3'h0;
    waveform_mode_field = 2'h0;
    wr_count(8'h00);
    clock_select_field = 3'h6;
    ext_count_pin = 1'b0;
    run(8);
    check("count_value", count_value, 8'h01);
    ext_count_pin = 1'b1;
    run(8);
    check("count_value", count_value, 8'h01);
    clock_select_field = 3'h2;
    run(65);
    check("count_value", count_value, 8'h09);
    $display("test tick source done");
    test_done();
  end
endmodule : tb_counter8_compare_unit

`default_nettype wire
